// ---- hdl/ffrp_defines.vh ----
// Purpose: Shared constants of the flash read path.
// Assumes: One core clock domain; byte addresses on the processor bus.
// Notes:   Definitions only; include by bare name.
`ifndef FFRP_DEFINES_VH
`define FFRP_DEFINES_VH

// ----------------------------------------
// Clocking and wait cycles
// ----------------------------------------
`define FFRP_CORE_MHZ 200
`define FFRP_WAIT_LIMIT_MHZ 60
// One extra code flash wait cycle when the core clock is above the limit.
`define FFRP_CF_WAIT ((`FFRP_CORE_MHZ > `FFRP_WAIT_LIMIT_MHZ) ? 1'b1 : 1'b0)

// ----------------------------------------
// Address windows
// ----------------------------------------
`define FFRP_CF_BASE_2M 32'hFFE00000
`define FFRP_CF_BASE_1M5 32'hFFE80000
`define FFRP_CF_BASE_1M 32'hFFF00000
`define FFRP_CF_SIZE_2M 22'h200000
`define FFRP_CF_SIZE_1M5 22'h180000
`define FFRP_CF_SIZE_1M 22'h100000
`define FFRP_CAP_2M 2'h0
`define FFRP_CAP_1M5 2'h1
`define FFRP_CAP_1M 2'h2
`define FFRP_DF_FIRST 32'h00100000
`define FFRP_DF_LAST 32'h00101FFF

// ----------------------------------------
// Read cache geometry: 8 KB, 16-byte lines, direct mapped
// ----------------------------------------
`define FFRP_LINE_W 128
`define FFRP_IDX_W 9
`define FFRP_LINES 512
`define FFRP_TAG_W 9

// ----------------------------------------
// Blocks and trusted blocks
// ----------------------------------------
`define FFRP_BLK_LSB 15
`define FFRP_TB_LO0 7'h08
`define FFRP_TB_LO1 7'h09
`define FFRP_TB_HI0 7'h2E
`define FFRP_TB_HI1 7'h2F

// ----------------------------------------
// Erased value of code flash
// ----------------------------------------
`define FFRP_ERASED_WORD 32'hFFFFFFFF
`define FFRP_ERASED_LINE {4{`FFRP_ERASED_WORD}}

`endif

// ---- hdl/ffrp_line_store.v ----
// Purpose: Tag, data and valid storage of the direct-mapped read cache.
// Assumes: Registered read port, one write port, no simultaneous hazards.
// Notes:   Only the valid bits are reset; data and tags need none.
`timescale 1ns/1ps
`include "ffrp_defines.vh"

module ffrp_line_store (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Invalidate all lines
  input wire inv,
  // Read port
  input wire rd_en,
  input wire [`FFRP_IDX_W-1:0] rd_idx,
  output reg [`FFRP_LINE_W-1:0] rd_line,
  output reg [`FFRP_TAG_W-1:0] rd_tag,
  output reg rd_valid,
  // Fill port
  input wire wr_en,
  input wire [`FFRP_IDX_W-1:0] wr_idx,
  input wire [`FFRP_TAG_W-1:0] wr_tag,
  input wire [`FFRP_LINE_W-1:0] wr_line
);

  reg [`FFRP_LINE_W-1:0] line_mem [0:`FFRP_LINES-1];
  reg [`FFRP_TAG_W-1:0] tag_mem [0:`FFRP_LINES-1];
  reg [`FFRP_LINES-1:0] valid_q;

  // A fill replaces the indexed entry whatever it held before.
  always @(posedge clk) begin
    if (wr_en) begin
      line_mem[wr_idx] <= wr_line;
      tag_mem[wr_idx] <= wr_tag;
    end
    if (rd_en) begin
      rd_line <= line_mem[rd_idx];
      rd_tag <= tag_mem[rd_idx];
    end
  end

  // Valid bits; a fill in the invalidate cycle still marks its line valid.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valid_q <= {`FFRP_LINES{1'b0}};
      rd_valid <= 1'b0;
    end else begin
      if (inv) begin
        valid_q <= {`FFRP_LINES{1'b0}};
      end
      if (wr_en) begin
        valid_q[wr_idx] <= 1'b1;
      end
      if (rd_en) begin
        rd_valid <= valid_q[rd_idx] & ~inv;
      end
    end
  end

endmodule

// ---- hdl/ffrp_top.v ----
// Purpose: Read path of the code flash and data flash on the core memory bus.
// Assumes: Flash arrays are plain logic on clk; options are static levels on clk.
// Notes:   Code flash fetches start at once and a cache hit cuts the wait short.
//
// Summary of operation
// - An 8 KB direct-mapped read cache with 16-byte lines fronts code flash.
// - Cached: hit in one cycle; miss as uncached, one cycle up to 60 MHz, else two.
// - Uncached code flash read: one cycle up to 60 MHz, else two.
// - Data flash takes and completes a read every cycle, no wait.
// - Erased code flash reads all ones; erased data flash reads undefined.
// - Code flash window ends at the top, base set by capacity.
// - Data flash decodes at 0010 0000h through 0010 1FFFh.
// - Linear mode maps code flash as one contiguous area.
// - Dual mode splits code flash into two separate banks.
// - Unauthorised reads of trusted blocks 8, 9 (dual: also 46, 47) are blocked.
`timescale 1ns/1ps
`include "ffrp_defines.vh"

module ffrp_top (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Configuration levels
  input wire cache_enable,
  input wire cache_invalidate,
  input wire dual_mode,
  input wire bank_swap,
  input wire [1:0] cap_sel,
  input wire trusted_block_protection,
  input wire trusted_access_ok,
  // Processor memory bus
  input wire req,
  input wire [31:0] addr,
  output reg ready_q,
  output reg ack_q,
  output reg err_q,
  output reg [31:0] rdata_q,
  // Code flash array
  output reg cf_rd_q,
  output reg [17:0] cf_line_addr_q,
  input wire [`FFRP_LINE_W-1:0] cf_line,
  input wire cf_blank,
  // Data flash array
  output reg df_rd_q,
  output reg [10:0] df_word_addr_q,
  input wire [31:0] df_word
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LOOK = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  reg [1:0] state_q;
  reg err_pend_q;
  reg [1:0] word_sel_q;
  reg [`FFRP_TAG_W-1:0] tag_q;
  reg [`FFRP_IDX_W-1:0] idx_q;
  reg [31:0] cf_base;
  reg [21:0] cf_size;
  reg [21:0] phys;
  reg blocked;
  wire [31:0] diff;
  wire [21:0] off;
  wire [21:0] half;
  wire [6:0] blk;
  wire is_cf;
  wire is_df;
  wire take;
  wire take_cf;
  wire [`FFRP_LINE_W-1:0] c_line;
  wire [`FFRP_TAG_W-1:0] c_tag;
  wire c_valid;
  wire hit;
  wire flash_done;
  wire fill;
  wire [`FFRP_LINE_W-1:0] fetched;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  always @* begin
    case (cap_sel)
      `FFRP_CAP_1M5: begin
        cf_base = `FFRP_CF_BASE_1M5;
        cf_size = `FFRP_CF_SIZE_1M5;
      end
      `FFRP_CAP_1M: begin
        cf_base = `FFRP_CF_BASE_1M;
        cf_size = `FFRP_CF_SIZE_1M;
      end
      default: begin
        cf_base = `FFRP_CF_BASE_2M;
        cf_size = `FFRP_CF_SIZE_2M;
      end
    endcase
  end

  // The window reaches the top of the address space, so only the base counts.
  assign is_cf = (addr >= cf_base);
  assign is_df = (addr >= `FFRP_DF_FIRST) && (addr <= `FFRP_DF_LAST);
  assign diff = addr - cf_base;
  assign off = diff[21:0];
  assign half = {1'b0, cf_size[21:1]};

  always @* begin
    phys = off;
    if (dual_mode && bank_swap) begin
      if (off >= half) begin
        phys = off - half;
      end else begin
        phys = off + half;
      end
    end
  end

  assign blk = phys[21:`FFRP_BLK_LSB];

  always @* begin
    blocked = 1'b0;
    if (trusted_block_protection && !trusted_access_ok) begin
      if ((blk == `FFRP_TB_LO0) || (blk == `FFRP_TB_LO1)) begin
        blocked = 1'b1;
      end
      if (dual_mode && ((blk == `FFRP_TB_HI0) || (blk == `FFRP_TB_HI1))) begin
        blocked = 1'b1;
      end
    end
  end

  assign take = req && ready_q;
  assign take_cf = take && is_cf && !blocked;

  // ----------------------------------------
  // Read cache
  // ----------------------------------------

  ffrp_line_store u_store (
    .clk(clk),
    .rstn(rstn),
    .inv(cache_invalidate),
    .rd_en(take_cf),
    .rd_idx(phys[12:4]),
    .rd_line(c_line),
    .rd_tag(c_tag),
    .rd_valid(c_valid),
    .wr_en(fill),
    .wr_idx(idx_q),
    .wr_tag(tag_q),
    .wr_line(fetched)
  );

  assign hit = cache_enable && c_valid && (c_tag == tag_q);
  assign flash_done = ((state_q == ST_LOOK) && !hit && !`FFRP_CF_WAIT) ||
                      (state_q == ST_WAIT);
  assign fetched = cf_blank ? `FFRP_ERASED_LINE : cf_line;
  assign fill = flash_done && cache_enable;

  // Picks one 32-bit word of a line.
  function [31:0] pick;
    input [`FFRP_LINE_W-1:0] line;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: pick = line[63:32];
        2'h2: pick = line[95:64];
        2'h3: pick = line[127:96];
        default: pick = line[31:0];
      endcase
    end
  endfunction

  // ----------------------------------------
  // Request sequencing
  // ----------------------------------------

  // Accepts requests, answers each once, and steps the code flash fetch.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b1;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h00000000;
      err_pend_q <= 1'b0;
      cf_rd_q <= 1'b0;
      cf_line_addr_q <= 18'h00000;
      df_rd_q <= 1'b0;
      df_word_addr_q <= 11'h000;
      word_sel_q <= 2'h0;
      tag_q <= {`FFRP_TAG_W{1'b0}};
      idx_q <= {`FFRP_IDX_W{1'b0}};
    end else begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      df_rd_q <= 1'b0;
      err_pend_q <= 1'b0;
      if (df_rd_q) begin
        ack_q <= 1'b1;
        rdata_q <= df_word;
      end
      // Refused accesses answer one cycle later with an error.
      if (err_pend_q) begin
        ack_q <= 1'b1;
        err_q <= 1'b1;
        rdata_q <= 32'h00000000;
      end
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            if (is_df) begin
              df_rd_q <= 1'b1;
              df_word_addr_q <= addr[12:2];
            end else if (take_cf) begin
              state_q <= ST_LOOK;
              ready_q <= 1'b0;
              cf_rd_q <= 1'b1;
              cf_line_addr_q <= phys[21:4];
              word_sel_q <= addr[3:2];
              tag_q <= phys[21:13];
              idx_q <= phys[12:4];
            end else begin
              err_pend_q <= 1'b1;
            end
          end
        end
        ST_LOOK: begin
          if (hit) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            cf_rd_q <= 1'b0;
            ack_q <= 1'b1;
            rdata_q <= pick(c_line, word_sel_q);
          end else if (!`FFRP_CF_WAIT) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            cf_rd_q <= 1'b0;
            ack_q <= 1'b1;
            rdata_q <= pick(fetched, word_sel_q);
          end else begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
          cf_rd_q <= 1'b0;
          ack_q <= 1'b1;
          rdata_q <= pick(fetched, word_sel_q);
        end
        default: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
          cf_rd_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- test/ffrp_flash_model.sv ----
// Purpose: Behavioural code flash and data flash arrays for the read path.
// Assumes: Contents are a pattern of the address; top quarter of 2 MB is erased.
// Notes:   Outside a read the outputs show the inverse, so stale data cannot pass.
`timescale 1ns/1ps
module ffrp_flash_model (
  // Code flash side
  input wire cf_rd_q,
  input wire [17:0] cf_line_addr_q,
  output logic [127:0] cf_line,
  output logic cf_blank,
  // Data flash side
  input wire df_rd_q,
  input wire [10:0] df_word_addr_q,
  output logic [31:0] df_word
);
  // Array words follow the address; idle lines carry the inverse.
  always @* begin
    for (int i = 0; i < 4; i++)
      cf_line[32*i +: 32] = {cf_line_addr_q, i[1:0], 12'hA5C};
    if (!cf_rd_q) cf_line = ~cf_line;
    cf_blank = cf_rd_q && (cf_line_addr_q[16:15] == 2'h3);
    df_word = {21'h0, df_word_addr_q} ^ 32'h5A000000;
    if (!df_rd_q) df_word = ~df_word;
  end
endmodule

// ---- test/ffrp_properties.sv ----
// Purpose: Bus timing checks of the flash read path.
// Assumes: Sees top ports only; trusted reads are authorised while bank swap is high.
// Notes:   Bound to the top from the bench.
`timescale 1ns/1ps
module ffrp_properties (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Options
  input wire cache_enable,
  input wire dual_mode,
  input wire [1:0] cap_sel,
  input wire trusted_block_protection,
  input wire trusted_access_ok,
  // Bus and arrays
  input wire req,
  input wire [31:0] addr,
  input wire ready_q,
  input wire ack_q,
  input wire err_q,
  input wire [31:0] rdata_q,
  input wire cf_rd_q,
  input wire df_rd_q,
  input wire [10:0] df_word_addr_q
);
  // ----
  // Decode
  // ----
  // Decode of the request as the bus presents it.
  wire [31:0] base = (cap_sel == 2'h1) ? 32'hFFE80000 :
    (cap_sel == 2'h2) ? 32'hFFF00000 : 32'hFFE00000;
  wire [31:0] off = addr - base;
  wire [6:0] blk = off[21:15];
  wire take = req && ready_q;
  wire [10:0] word = addr[12:2];
  wire df = addr[31:13] == 19'h00080;
  wire cf = addr >= base;
  wire hot = blk == 7'h08 || blk == 7'h09 || (dual_mode && (blk == 7'h2E || blk == 7'h2F));
  wire blocked = trusted_block_protection && !trusted_access_ok && hot;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_DF_ACK: assert property (take && df |=> ##1 ack_q && !err_q && ready_q)
    else $error("data flash answer late");
  AST_DF_ADDR: assert property (take && df |=> df_rd_q && df_word_addr_q == $past(word))
    else $error("data flash word address wrong");
  AST_UNMAP: assert property (take && !df && !cf |=> ##1 ack_q && err_q && rdata_q == 32'h0)
    else $error("unmapped access not refused");
  AST_NOCACHE: assert property (take && cf && !blocked && !cache_enable |=>
    !ack_q && !ready_q && cf_rd_q ##1 !ack_q && !ready_q ##1 ack_q && !err_q)
    else $error("uncached wait wrong");
  AST_CACHED: assert property (take && cf && !blocked && cache_enable |=>
    cf_rd_q ##[1:2] ack_q && !err_q) else $error("cached read wait wrong");
  AST_BLOCK: assert property (take && cf && blocked |=> ##1 ack_q && err_q)
    else $error("trusted block read not refused");
  AST_ERR_ZERO: assert property (err_q |-> ack_q && rdata_q == 32'h0)
    else $error("refused answer carries data");
  AST_READY_BACK: assert property ($rose(ready_q) |-> ack_q)
    else $error("ready returned without answer");
  // Main scenarios reached.
  cover property (take && cf && cache_enable ##2 ack_q && !err_q);
  cover property (take && df ##1 take && df);
  cover property (take && blocked ##2 err_q);
endmodule

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench of the flash read path.
// Assumes: Core clock 200 MHz, so a code flash miss takes two cycles.
// Notes:   Inputs change on the falling edge; bank swap rises only with trusted reads allowed.
`timescale 1ns/1ps
module tb_top;
  // Bench signals.
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cache_enable = 1'b0;
  logic cache_invalidate = 1'b0;
  logic dual_mode = 1'b0;
  logic bank_swap = 1'b0;
  logic [1:0] cap_sel = 2'h0;
  logic trusted_block_protection = 1'b0;
  logic trusted_access_ok = 1'b0;
  logic req = 1'b0;
  logic [31:0] addr = 32'h0;
  wire ready_q, ack_q, err_q, cf_rd_q, cf_blank, df_rd_q;
  wire [31:0] rdata_q;
  wire [31:0] df_word;
  wire [17:0] cf_line_addr_q;
  wire [10:0] df_word_addr_q;
  wire [127:0] cf_line;
  int err_total = 0;
  int check_count = 0;
  ffrp_top dut (
    .clk(clk), .rstn(rstn),
    .cache_enable(cache_enable), .cache_invalidate(cache_invalidate),
    .dual_mode(dual_mode), .bank_swap(bank_swap), .cap_sel(cap_sel),
    .trusted_block_protection(trusted_block_protection),
    .trusted_access_ok(trusted_access_ok),
    .req(req), .addr(addr), .ready_q(ready_q), .ack_q(ack_q), .err_q(err_q),
    .rdata_q(rdata_q),
    .cf_rd_q(cf_rd_q), .cf_line_addr_q(cf_line_addr_q), .cf_line(cf_line),
    .cf_blank(cf_blank),
    .df_rd_q(df_rd_q), .df_word_addr_q(df_word_addr_q), .df_word(df_word)
  );
  ffrp_flash_model u_flash (
    .cf_rd_q(cf_rd_q), .cf_line_addr_q(cf_line_addr_q), .cf_line(cf_line),
    .cf_blank(cf_blank),
    .df_rd_q(df_rd_q), .df_word_addr_q(df_word_addr_q), .df_word(df_word)
  );
  // Core clock, 5 ns period.
  always #2.5 clk = ~clk;
  // ----
  // Helpers
  // ----
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected code flash word: erased region reads all ones.
  function automatic logic [31:0] cf_exp(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] off;
    off = a - b;
    cf_exp = (off[20:19] == 2'h3) ? 32'hFFFFFFFF : {off[21:4], a[3:2], 12'hA5C};
  endfunction
  // One read; checks cycles to answer, refusal and data.
  task automatic rd(input logic [31:0] a, input int lat, input logic er, input logic [31:0] d);
    int n;
    @(negedge clk);
    req = 1'b1;
    addr = a;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (ack_q !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    cmp(32'(n), 32'(lat));
    cmp(err_q, er);
    cmp(rdata_q, d);
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_df;
    @(negedge clk);
    req = 1'b1;
    addr = 32'h00100000;
    @(negedge clk);
    addr = 32'h00101FFC;
    @(negedge clk);
    req = 1'b0;
    cmp(ack_q, 1'b1);
    cmp(rdata_q, 32'h5A000000);
    @(negedge clk);
    cmp(ack_q, 1'b1);
    cmp(rdata_q, 32'h5A0007FF);
    rd(32'h00102000, 1, 1'b1, 32'h0);
    rd(32'h000FFFFC, 1, 1'b1, 32'h0);
    $display("test df done");
  endtask
  task automatic t_cf;
    rd(32'hFFE00010, 2, 1'b0, cf_exp(32'hFFE00010, 32'hFFE00000));
    cache_enable = 1'b1;
    rd(32'hFFE0001C, 2, 1'b0, cf_exp(32'hFFE0001C, 32'hFFE00000));
    rd(32'hFFE00014, 1, 1'b0, cf_exp(32'hFFE00014, 32'hFFE00000));
    rd(32'hFFE0201C, 2, 1'b0, cf_exp(32'hFFE0201C, 32'hFFE00000));
    rd(32'hFFE00018, 2, 1'b0, cf_exp(32'hFFE00018, 32'hFFE00000));
    rd(32'hFFE00018, 1, 1'b0, cf_exp(32'hFFE00018, 32'hFFE00000));
    cache_invalidate = 1'b1;
    @(negedge clk);
    cache_invalidate = 1'b0;
    rd(32'hFFE00018, 2, 1'b0, cf_exp(32'hFFE00018, 32'hFFE00000));
    rd(32'hFFFFFF00, 2, 1'b0, 32'hFFFFFFFF);
    cache_enable = 1'b0;
    $display("test cf done");
  endtask
  task automatic t_map;
    logic [31:0] b [3] = '{32'hFFE00000, 32'hFFE80000, 32'hFFF00000};
    for (int c = 0; c < 3; c++) begin
      cap_sel = c[1:0];
      rd(b[c] - 32'h4, 1, 1'b1, 32'h0);
      rd(b[c], 2, 1'b0, cf_exp(b[c], b[c]));
    end
    cap_sel = 2'h0;
    $display("test map done");
  endtask
  task automatic t_trust;
    trusted_block_protection = 1'b1;
    rd(32'hFFE40000, 1, 1'b1, 32'h0);
    rd(32'hFFE4FFFC, 1, 1'b1, 32'h0);
    rd(32'hFFF70000, 2, 1'b0, cf_exp(32'hFFF70000, 32'hFFE00000));
    dual_mode = 1'b1;
    rd(32'hFFF70000, 1, 1'b1, 32'h0);
    rd(32'hFFF7FFFC, 1, 1'b1, 32'h0);
    trusted_access_ok = 1'b1;
    rd(32'hFFE40000, 2, 1'b0, cf_exp(32'hFFE40000, 32'hFFE00000));
    bank_swap = 1'b1;
    rd(32'hFFE00010, 2, 1'b0, cf_exp(32'hFFF00010, 32'hFFE00000));
    rd(32'hFFF00010, 2, 1'b0, cf_exp(32'hFFE00010, 32'hFFE00000));
    $display("test trust done");
  endtask
  // Main sequence after three cycles of reset.
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_df;
    t_cf;
    t_map;
    t_trust;
    conclude;
  end
  // Watchdog well beyond the hundred or so cycles the tests need.
  initial begin
    #10000;
    err_total++;
    conclude;
  end
endmodule
bind ffrp_top ffrp_properties u_props (
  .clk(clk), .rstn(rstn), .cache_enable(cache_enable), .dual_mode(dual_mode),
  .cap_sel(cap_sel), .trusted_block_protection(trusted_block_protection),
  .trusted_access_ok(trusted_access_ok), .req(req), .addr(addr),
  .ready_q(ready_q), .ack_q(ack_q), .err_q(err_q), .rdata_q(rdata_q),
  .cf_rd_q(cf_rd_q), .df_rd_q(df_rd_q), .df_word_addr_q(df_word_addr_q)
);
